//--- core/eeprom_port_config_preload.v
/*
  eeprom preload of per-port configuration fields for a three-port switch.
  after reset (or a software reload) the block reads eeprom words 54h, 55h,
  60h, 62h and 64h through a simple word-read port and copies their fields
  into the configuration-space bits it drives. registers sit on apb.
  assumes an eeprom reader that answers each request with one ack pulse,
  flagging missing words with eeRdAbsent, and that config space holds off
  requests while cfgReady is low.
  register map, one aligned 32-bit word each:
    000h control: write bit 0 to ask for a reload; reads the pending flag
    004h status: bit 0 busy, bit 1 ready, bits 6:2 absent flags of the words
    008h raw word 54h, 00Ch raw word 55h
    010h raw word 60h, 014h raw word 62h, 018h raw word 64h
    any other offset answers with pslverr and reads as zero
  output fields and the configuration bits they feed:
    pmAuxCurrent 40h[24:22], pmD1Support 40h[25], pmD2Support 40h[26]
    pmPmeD2D1 40h[29:28], pmData 44h[31:24], noSoftReset 44h[3]; port 2 only
    slotClkCfg D0h[28], dsiNeeded 40h[21], lpvcVc1 144h[4]; bit n is port n
    logicalPortNum CCh[26:24], tcVc0Map 154h[7:1]; one slice per port
    slotImpl C0h[24]; ports 1 and 2 only
  limitations: a reload only overwrites fields from present words, so a
  word that goes missing later keeps its older value; a reload written
  during a pass is remembered and run after it, with ready held low.
  eeRdAddr only moves on an ack, so a reader that acks twice for one
  request would skip a word.
*/
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// - aux current word bits 3:1 to 40h[24:22]
// - word bit 4 to D1 support 40h[25]
// - word bit 5 to D2 support 40h[26]
// - word bits 7:6 to PME support 40h[29:28]
// - word 55h bits 15:8 to 44h[31:24]
// - port words at 60h, 62h, 64h
// - port word bit 1 to D0h[28] slot clock
// - port word bit 2 to 40h[21] dsi
// - port word bit 3 to 144h[4] lpvc
// - port word bits 6:4 to CCh[26:24]
// - port word bits 15:9 to 154h[7:1]
// - ports 1,2 bit 0 to C0h[24] slot
// - word 54h bit 0 to 44h[3]
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_port_config_preload_defs.vh"

module eeprom_port_config_preload (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // eeprom word-read port
  output reg         eeRdReq,
  output reg  [7:0]  eeRdAddr,
  input  wire        eeRdAck,
  input  wire        eeRdAbsent,
  input  wire [15:0] eeRdData,
  // configuration readiness
  output wire        cfgReady,
  // port 2 power management fields
  output reg  [2:0]  pmAuxCurrent,
  output reg         pmD1Support,
  output reg         pmD2Support,
  output reg  [1:0]  pmPmeD2D1,
  output reg  [7:0]  pmData,
  output reg         noSoftReset,
  // per-port fields, port n in bit n or slice n
  output reg  [2:0]  slotClkCfg,
  output reg  [2:0]  dsiNeeded,
  output reg  [2:0]  lpvcVc1,
  output reg  [8:0]  logicalPortNum,
  output reg  [20:0] tcVc0Map,
  output reg  [2:1]  slotImpl
);

  // one-hot loader states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_REQ  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // loader state, word index and reload request
  reg  [2:0]  state_q;
  reg  [2:0]  idx_q;
  reg         pending_q;

  // absent flags and raw words as last read, for software
  reg  [4:0]  absent_q;
  reg  [15:0] wordP2Pm_q;
  reg  [15:0] wordP2Data_q;
  reg  [15:0] wordPort0_q;
  reg  [15:0] wordPort1_q;
  reg  [15:0] wordPort2_q;

  // word index to eeprom address
  function [7:0] eeAddrOf;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    eeAddrOf = `EE_ADDR_P2_PMCAP;
        3'h1:    eeAddrOf = `EE_ADDR_P2_PMDATA;
        3'h2:    eeAddrOf = `EE_ADDR_PORT0;
        3'h3:    eeAddrOf = `EE_ADDR_PORT1;
        default: eeAddrOf = `EE_ADDR_PORT2;
      endcase
    end
  endfunction

  // apb: zero wait states, unmapped addresses flag an error
  wire apbSetup  = psel & ~penable;
  wire apbAccess = psel & penable;
  wire mapped    = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
                   (paddr == `REG_WORD_P2PM) || (paddr == `REG_WORD_P2DATA) ||
                   (paddr == `REG_WORD_PORT0) || (paddr == `REG_WORD_PORT1) ||
                   (paddr == `REG_WORD_PORT2);

  // no wait states: every access ends in its first cycle
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~mapped;

  // a reload request while busy is held until the current pass ends
  wire reloadWr = apbAccess & pwrite & (paddr == `REG_CTRL) & pwdata[`CTRL_RELOAD_BIT];

  // config space must wait for the pass to finish
  assign cfgReady = state_q[2] & ~pending_q;

  // read data is captured in the setup cycle so it is a flop in the access cycle
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      if (paddr == `REG_CTRL) begin
        prdata <= {31'h00000000, pending_q};
      end else if (paddr == `REG_STATUS) begin
        prdata <= {25'h0000000, absent_q, cfgReady, ~state_q[2]};
      end else if (paddr == `REG_WORD_P2PM) begin
        prdata <= {16'h0000, wordP2Pm_q};
      end else if (paddr == `REG_WORD_P2DATA) begin
        prdata <= {16'h0000, wordP2Data_q};
      end else if (paddr == `REG_WORD_PORT0) begin
        prdata <= {16'h0000, wordPort0_q};
      end else if (paddr == `REG_WORD_PORT1) begin
        prdata <= {16'h0000, wordPort1_q};
      end else if (paddr == `REG_WORD_PORT2) begin
        prdata <= {16'h0000, wordPort2_q};
      end else begin
        // unmapped offsets read as zero
        prdata <= 32'h00000000;
      end
    end
  end

  // loader sequence: a pass starts by itself after reset
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // no request leaves while reset is high
      state_q   <= ST_IDLE;
      idx_q     <= 3'h0;
      pending_q <= 1'b0;
      eeRdReq   <= 1'b0;
      eeRdAddr  <= 8'h00;
    end else begin
      // a reload may be asked for at any time
      if (reloadWr) begin
        pending_q <= 1'b1;
      end
      case (state_q)
        // start a pass at the first word
        ST_IDLE: begin
          idx_q    <= 3'h0;
          eeRdReq  <= 1'b1;
          eeRdAddr <= eeAddrOf(3'h0);
          state_q  <= ST_REQ;
        end

        // step to the next word on each ack
        ST_REQ: begin
          if (eeRdAck) begin
            if (idx_q == `EE_WORD_COUNT - 3'h1) begin
              eeRdReq <= 1'b0;
              state_q <= ST_DONE;
            end else begin
              idx_q    <= idx_q + 3'h1;
              eeRdAddr <= eeAddrOf(idx_q + 3'h1);
            end
          end
        end

        // rest until software asks for a reload
        ST_DONE: begin
          // a reload written in the same cycle wins over the clear of the pending flag
          if (pending_q) begin
            pending_q <= reloadWr;
            state_q   <= ST_IDLE;
          end
        end

        // an illegal code falls back to idle
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // raw words and their absent flags, kept for software
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // raw words read as zero until first loaded
      absent_q     <= 5'h00;
      wordP2Pm_q   <= 16'h0000;
      wordP2Data_q <= 16'h0000;
      wordPort0_q  <= 16'h0000;
      wordPort1_q  <= 16'h0000;
      wordPort2_q  <= 16'h0000;
    end else if (state_q[1] & eeRdAck) begin
      absent_q[idx_q] <= eeRdAbsent;
      // an absent word keeps the value software last saw
      if (!eeRdAbsent) begin
        case (idx_q)
          3'h0:    wordP2Pm_q   <= eeRdData;
          3'h1:    wordP2Data_q <= eeRdData;
          3'h2:    wordPort0_q  <= eeRdData;
          3'h3:    wordPort1_q  <= eeRdData;
          default: wordPort2_q  <= eeRdData;
        endcase
      end
    end
  end

  // field copies; an absent word leaves the fields at their last loaded values, or defaults if never loaded
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      // defaults hold until a present word overwrites them
      pmAuxCurrent   <= `DEF_AUX_CURRENT;
      pmD1Support    <= `DEF_D1_SUPPORT;
      pmD2Support    <= `DEF_D2_SUPPORT;
      pmPmeD2D1      <= `DEF_PME_D2D1;
      pmData         <= `DEF_PM_DATA;
      noSoftReset    <= `DEF_NO_SOFT_RESET;
      slotClkCfg     <= 3'h0;
      dsiNeeded      <= 3'h0;
      lpvcVc1        <= 3'h0;
      logicalPortNum <= {`DEF_PORT_NUM_P2, `DEF_PORT_NUM_P1, `DEF_PORT_NUM_P0};
      tcVc0Map       <= 21'h000000;
      slotImpl       <= 2'h0;
    end else if (state_q[1] & eeRdAck & ~eeRdAbsent) begin
      case (idx_q)
        // word 54h: port 2 power management capability
        3'h0: begin
          noSoftReset  <= eeRdData[`PM_NOSOFTRST_BIT];
          pmAuxCurrent <= eeRdData[`PM_AUX_HI:`PM_AUX_LO];
          pmD1Support  <= eeRdData[`PM_D1_BIT];
          pmD2Support  <= eeRdData[`PM_D2_BIT];
          pmPmeD2D1    <= eeRdData[`PM_PME_HI:`PM_PME_LO];
        end

        // word 55h: port 2 power management data
        3'h1: begin
          pmData <= eeRdData[`PM_DATA_HI:`PM_DATA_LO];
        end

        // word 60h: port 0
        3'h2: begin
          // port 0 has no slot implemented bit
          slotClkCfg[0]          <= eeRdData[`PW_SLOTCLK_BIT];
          dsiNeeded[0]           <= eeRdData[`PW_DSI_BIT];
          lpvcVc1[0]             <= eeRdData[`PW_LPVC_BIT];
          logicalPortNum[2:0]    <= eeRdData[`PW_PORTNUM_HI:`PW_PORTNUM_LO];
          tcVc0Map[6:0]          <= eeRdData[`PW_TCMAP_HI:`PW_TCMAP_LO];
        end

        // word 62h: port 1
        3'h3: begin
          slotImpl[1]            <= eeRdData[`PW_SLOTIMPL_BIT];
          slotClkCfg[1]          <= eeRdData[`PW_SLOTCLK_BIT];
          dsiNeeded[1]           <= eeRdData[`PW_DSI_BIT];
          lpvcVc1[1]             <= eeRdData[`PW_LPVC_BIT];
          logicalPortNum[5:3]    <= eeRdData[`PW_PORTNUM_HI:`PW_PORTNUM_LO];
          tcVc0Map[13:7]         <= eeRdData[`PW_TCMAP_HI:`PW_TCMAP_LO];
        end

        // word 64h: port 2
        default: begin
          slotImpl[2]            <= eeRdData[`PW_SLOTIMPL_BIT];
          slotClkCfg[2]          <= eeRdData[`PW_SLOTCLK_BIT];
          dsiNeeded[2]           <= eeRdData[`PW_DSI_BIT];
          lpvcVc1[2]             <= eeRdData[`PW_LPVC_BIT];
          logicalPortNum[8:6]    <= eeRdData[`PW_PORTNUM_HI:`PW_PORTNUM_LO];
          tcVc0Map[20:14]        <= eeRdData[`PW_TCMAP_HI:`PW_TCMAP_LO];
        end
      endcase
    end
  end

endmodule // eeprom_port_config_preload

`default_nettype wire

//--- core/eeprom_port_config_preload_defs.vh
/*
  constants of the eeprom preload block: eeprom word addresses, field
  positions inside those words, apb register offsets and reset defaults.
  assumes it is included by bare name from the design file.
*/
`ifndef EEPROM_PORT_CONFIG_PRELOAD_DEFS_VH
`define EEPROM_PORT_CONFIG_PRELOAD_DEFS_VH

// eeprom word addresses
`define EE_ADDR_P2_PMCAP   8'h54
`define EE_ADDR_P2_PMDATA  8'h55
`define EE_ADDR_PORT0      8'h60
`define EE_ADDR_PORT1      8'h62
`define EE_ADDR_PORT2      8'h64
`define EE_WORD_COUNT      3'h5

// fields of the power management word
`define PM_NOSOFTRST_BIT   0
`define PM_AUX_HI          3
`define PM_AUX_LO          1
`define PM_D1_BIT          4
`define PM_D2_BIT          5
`define PM_PME_HI          7
`define PM_PME_LO          6
`define PM_DATA_HI         15
`define PM_DATA_LO         8

// fields of the per-port word
`define PW_SLOTIMPL_BIT    0
`define PW_SLOTCLK_BIT     1
`define PW_DSI_BIT         2
`define PW_LPVC_BIT        3
`define PW_PORTNUM_HI      6
`define PW_PORTNUM_LO      4
`define PW_TCMAP_HI        15
`define PW_TCMAP_LO        9

// apb register byte offsets
`define REG_CTRL           12'h000
`define REG_STATUS         12'h004
`define REG_WORD_P2PM      12'h008
`define REG_WORD_P2DATA    12'h00C
`define REG_WORD_PORT0     12'h010
`define REG_WORD_PORT1     12'h014
`define REG_WORD_PORT2     12'h018
`define CTRL_RELOAD_BIT    0

// hardware defaults loaded at reset, kept while a word has never been present
`define DEF_AUX_CURRENT    3'h0
`define DEF_D1_SUPPORT     1'h1
`define DEF_D2_SUPPORT     1'h1
`define DEF_PME_D2D1       2'h0
`define DEF_PM_DATA        8'h00
`define DEF_NO_SOFT_RESET  1'h0
`define DEF_PORT_WORD      16'h0000
`define DEF_PORT_NUM_P0    3'h0
`define DEF_PORT_NUM_P1    3'h1
`define DEF_PORT_NUM_P2    3'h2

`endif

//--- sim/preload_assertions.sv
/* port assertions for the eeprom preload block; bound from the bench top file */
`timescale 1ns/1ps
`default_nettype none
module preload_checker (
  // clock, reset, apb
  input wire logic        core_clk, reset, psel, penable, pslverr,
  input wire logic [11:0] paddr,
  // eeprom port and readiness
  input wire logic        eeRdReq, eeRdAck, eeRdAbsent, cfgReady,
  input wire logic [7:0]  eeRdAddr,
  input wire logic [15:0] eeRdData,
  // loaded fields
  input wire logic [2:0]  pmAuxCurrent, slotClkCfg, dsiNeeded, lpvcVc1,
  input wire logic        pmD1Support, pmD2Support, noSoftReset,
  input wire logic [1:0]  pmPmeD2D1,
  input wire logic [7:0]  pmData,
  input wire logic [8:0]  logicalPortNum,
  input wire logic [20:0] tcVc0Map,
  input wire logic [2:1]  slotImpl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // a word counts only when acked while a read is wanted
  wire take = eeRdReq && eeRdAck;
  wire good = take && !eeRdAbsent;
  a_first_word: assert property (!eeRdReq ##1 eeRdReq |-> eeRdAddr == 8'h54)
    else $error("pass starts at wrong word");
  a_word_order: assert property (take && eeRdAddr != 8'h64 |=> eeRdReq && eeRdAddr == ($past(eeRdAddr) == 8'h54 ? 8'h55 :
    $past(eeRdAddr) == 8'h55 ? 8'h60 : $past(eeRdAddr) + 8'h02)) else $error("word order broken");
  a_pass_end: assert property (take && eeRdAddr == 8'h64 |=> !eeRdReq ##[0:1] cfgReady)
    else $error("pass did not finish");
  a_ready_quiet: assert property (cfgReady |-> !eeRdReq) else $error("ready while reading");
  a_pm_word: assert property (good && eeRdAddr == 8'h54 |=>
    {pmPmeD2D1, pmD2Support, pmD1Support, pmAuxCurrent, noSoftReset} == $past(eeRdData[7:0])) else $error("pm word");
  a_pm_data: assert property (good && eeRdAddr == 8'h55 |=> pmData == $past(eeRdData[15:8]))
    else $error("pm data byte");
  a_port0_word: assert property (good && eeRdAddr == 8'h60 |=> {tcVc0Map[6:0], logicalPortNum[2:0],
    lpvcVc1[0], dsiNeeded[0], slotClkCfg[0]} == {$past(eeRdData[15:9]), $past(eeRdData[6:1])}) else $error("port 0 word");
  a_port1_word: assert property (good && eeRdAddr == 8'h62 |=> {tcVc0Map[13:7], logicalPortNum[5:3],
    lpvcVc1[1], dsiNeeded[1], slotClkCfg[1], slotImpl[1]} == {$past(eeRdData[15:9]), $past(eeRdData[6:0])})
    else $error("port 1 word");
  a_port2_word: assert property (good && eeRdAddr == 8'h64 |=> {tcVc0Map[20:14], logicalPortNum[8:6],
    lpvcVc1[2], dsiNeeded[2], slotClkCfg[2], slotImpl[2]} == {$past(eeRdData[15:9]), $past(eeRdData[6:0])})
    else $error("port 2 word");
  a_absent_keep: assert property (take && eeRdAbsent |=> $stable(pmData) && $stable(tcVc0Map))
    else $error("absent word changed a field");
  a_apb_error: assert property (psel && penable && paddr > 12'h018 |-> pslverr) else $error("unmapped not flagged");
endmodule // preload_checker
`default_nettype wire

//--- sim/eeprom_word_model.sv
/* behavioural eeprom behind the word-read port; the bench fills mem and miss
   and sets slow, the idle cycles before each ack */
`timescale 1ns/1ps
`default_nettype none
module eeprom_word_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // word-read port
  input  wire logic        eeRdReq,
  input  wire logic [7:0]  eeRdAddr,
  output var  logic        eeRdAck = 1'b0,
  output var  logic        eeRdAbsent = 1'b0,
  output var  logic [15:0] eeRdData = 16'h0000
);
  logic [15:0] mem [0:255];
  logic        miss [0:255];
  int          slow = 0;
  int          waitCnt = 0;
  // lines toggle when not valid so a stale word never looks fresh
  always @(posedge core_clk) begin
    eeRdAck <= 1'b0;
    eeRdData <= ~eeRdData;
    eeRdAbsent <= ~eeRdAbsent;
    if (!reset && eeRdReq && !eeRdAck) begin
      if (waitCnt >= slow) begin
        eeRdAck <= 1'b1;
        eeRdData <= mem[eeRdAddr];
        eeRdAbsent <= miss[eeRdAddr];
        waitCnt <= 0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule // eeprom_word_model
`default_nettype wire

//--- sim/test_eeprom_port_config_preload.sv
/* self-checking bench: apb master, eeprom model, queued expectations
   assumes the design header is on the include path */
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_port_config_preload_defs.vh"
module test_eeprom_port_config_preload;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rdyPrev = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, eeRdReq, eeRdAck, eeRdAbsent, cfgReady, pmD1Support, pmD2Support, noSoftReset;
  logic [7:0] eeRdAddr, pmData;
  logic [15:0] eeRdData, w[5], rw[5];
  logic [2:0] pmAuxCurrent, slotClkCfg, dsiNeeded, lpvcVc1;
  logic [1:0] pmPmeD2D1;
  logic [8:0] logicalPortNum;
  logic [20:0] tcVc0Map;
  logic [2:1] slotImpl;
  logic [4:0] m;
  logic [63:0] rq[$], fq[$];
  logic [7:0] ad[5] = '{`EE_ADDR_P2_PMCAP, `EE_ADDR_P2_PMDATA, `EE_ADDR_PORT0, `EE_ADDR_PORT1, `EE_ADDR_PORT2};
  logic [56:0] ef = {3'h0, 1'h1, 1'h1, 2'h0, 8'h00, 1'h0, 9'h000, 9'h088, 21'h0, 2'h0}; // reset defaults
  wire logic [56:0] fields = {pmAuxCurrent, pmD1Support, pmD2Support, pmPmeD2D1, pmData, noSoftReset,
    slotClkCfg, dsiNeeded, lpvcVc1, logicalPortNum, tcVc0Map, slotImpl};
  int errors = 0, samples_checked = 0, seed = 19;
  eeprom_port_config_preload uut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr),
    .eeRdAck(eeRdAck), .eeRdAbsent(eeRdAbsent), .eeRdData(eeRdData), .cfgReady(cfgReady),
    .pmAuxCurrent(pmAuxCurrent), .pmD1Support(pmD1Support), .pmD2Support(pmD2Support), .pmPmeD2D1(pmPmeD2D1),
    .pmData(pmData), .noSoftReset(noSoftReset), .slotClkCfg(slotClkCfg), .dsiNeeded(dsiNeeded),
    .lpvcVc1(lpvcVc1), .logicalPortNum(logicalPortNum), .tcVc0Map(tcVc0Map), .slotImpl(slotImpl));
  eeprom_word_model ee (
    .core_clk(core_clk), .reset(reset), .eeRdReq(eeRdReq), .eeRdAddr(eeRdAddr), .eeRdAck(eeRdAck),
    .eeRdAbsent(eeRdAbsent), .eeRdData(eeRdData));
  initial forever #10 core_clk = ~core_clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin errors++; summarize(); end
    {psel, penable} <= 2'b00;
  endtask
  // fill the eeprom and predict the fields one pass leaves behind
  task automatic pass(input logic [4:0] mm);
    m = mm;
    for (int i = 0; i < 5; i++) begin
      w[i] = 16'($random(seed));
      ee.mem[ad[i]] = w[i];
      ee.miss[ad[i]] = m[i];
      if (!m[i]) rw[i] = w[i];
    end
    ee.slow = $random(seed) & 3;
    if (!m[0]) ef[56:50] = {w[0][3:1], w[0][4], w[0][5], w[0][7:6]};
    if (!m[0]) ef[41] = w[0][0];
    if (!m[1]) ef[49:42] = w[1][15:8];
    for (int p = 0; p < 3; p++) if (!m[p + 2]) begin
      {ef[32 + p], ef[35 + p], ef[38 + p]} = w[p + 2][3:1]; // lpvc, dsi, slot clock
      ef[23 + 3 * p +: 3] = w[p + 2][6:4];
      ef[2 + 7 * p +: 7] = w[p + 2][15:9];
      if (p > 0) ef[p - 1] = w[p + 2][0];
    end
    fq.push_back(64'(ef));
  endtask
  // bounded wait for the pass, then status and raw words over apb
  task automatic settle;
    int n;
    repeat (2) @(posedge core_clk);
    for (n = 0; n < 300 && cfgReady !== 1'b1; n++) @(posedge core_clk);
    if (n == 300) begin errors++; summarize(); end
    rq.push_back({57'h0, m, 2'b10});
    apb(1'b0, `REG_STATUS, 32'h0);
    rq.push_back(64'h0); // no reload left pending once ready
    apb(1'b0, `REG_CTRL, 32'h0);
    for (int i = 0; i < 5; i++) if (!m[i]) begin
      rq.push_back(64'(rw[i]));
      apb(1'b0, 12'(`REG_WORD_P2PM + 4 * i), 32'h0);
    end
  endtask
  // results are compared as they appear, oldest note first
  always @(posedge core_clk) begin
    rdyPrev <= cfgReady;
    if (psel && penable && pready && !pwrite) check(prdata, rq.pop_front());
    if (cfgReady && !rdyPrev) check(fields, fq.pop_front());
  end
  initial begin
    pass(5'h1F); // every word absent: defaults must survive
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    for (int k = 0; k < 5; k++) begin
      pass(k == 0 ? 5'h00 : 5'($random(seed)));
      apb(1'b1, `REG_CTRL, 32'h1);
      settle();
    end
    rq.push_back(64'h0);
    apb(1'b0, 12'h01C, 32'h0);
    summarize();
  end
endmodule // test_eeprom_port_config_preload
bind eeprom_port_config_preload preload_checker chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pslverr(pslverr), .paddr(paddr),
  .eeRdReq(eeRdReq), .eeRdAck(eeRdAck), .eeRdAbsent(eeRdAbsent), .cfgReady(cfgReady), .eeRdAddr(eeRdAddr),
  .eeRdData(eeRdData), .pmAuxCurrent(pmAuxCurrent), .slotClkCfg(slotClkCfg), .dsiNeeded(dsiNeeded),
  .lpvcVc1(lpvcVc1), .pmD1Support(pmD1Support), .pmD2Support(pmD2Support), .noSoftReset(noSoftReset),
  .pmPmeD2D1(pmPmeD2D1), .pmData(pmData), .logicalPortNum(logicalPortNum), .tcVc0Map(tcVc0Map),
  .slotImpl(slotImpl));
`default_nettype wire
